// >>> hdl/ebt_defs.vh
// Constants for the eight-bit timer: register offsets, fields, codes, reset values
`ifndef EBT_DEFS_VH
`define EBT_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define EBT_OFS_COUNTER   12'h000
`define EBT_OFS_CONTROL   12'h004
`define EBT_OFS_MASK      12'h008
`define EBT_OFS_FLAGS     12'h00c
`define EBT_OFS_IRQ_STAT  12'h010
`define EBT_OFS_IRQ_MASK  12'h014

// ****************************************
// Field positions
// ****************************************
`define EBT_CTRL_CS_LSB   0
`define EBT_CTRL_CS_MSB   2
`define EBT_CTRL_PSR_BIT  3
`define EBT_CTRL_GIE_BIT  4
`define EBT_MASK_TOIE_BIT 0
`define EBT_FLAG_TOV_BIT  0
`define EBT_STAT_OVF_BIT  0
`define EBT_STAT_EXT_BIT  1

// ****************************************
// Clock select codes
// ****************************************
`define EBT_CS_STOP       3'h0
`define EBT_CS_DIV1       3'h1
`define EBT_CS_DIV8       3'h2
`define EBT_CS_DIV64      3'h3
`define EBT_CS_DIV256     3'h4
`define EBT_CS_DIV1024    3'h5
`define EBT_CS_EXT_FALL   3'h6
`define EBT_CS_EXT_RISE   3'h7

// ****************************************
// Prescaler and reset values
// ****************************************
`define EBT_PRE_WIDTH     10
`define EBT_COUNT_RESET   8'h00
`define EBT_MAX_VALUE     8'hff
`define EBT_CS_RESET      3'h0

`endif

// >>> hdl/ebt_timer.v
// Eight-bit up-counting timer with shared prescaler, external pin count and APB slave
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
// Operation
// - Each selected tick adds one, upward only
// - Clock select zero stops counter, no ticks
// - Counter readable and writable at any time
// - Software write beats a same-cycle count
// - No self clear; wraps 0xff to zero
// - Overflow flag set on wrap tick
// - Codes 1..5 pick /1,/8,/64,/256,/1024
// - Code 6 falling, 7 rising pin edge
// - Pin edges count even when driven locally
// - Irq needs global enable, mask, flag; here timer_irq_req only, irq needs just status and irq mask
// - Flag cleared by vector ack or write-one
// - Prescaler free running, shared with other timer
// - First prescaled count within 1..N+1 cycles
// - Prescaler reset restarts every sharing timer
// - Pin sampled each clock before edge detect
// - Prescaler reset bit self clears, reads zero
// - Counter updates 2.5..3.5 cycles after edge; here 3..4 cycles
`include "ebt_defs.vh"

module ebt_timer #(
   parameter PRE_WIDTH = `EBT_PRE_WIDTH    // Prescaler counter width
)(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        count_input_pin,
   input  wire        ovf_vector_ack,
   input  wire        ext_prescaler_reset,
   output reg         prescaler_reset_out,
   output reg  [PRE_WIDTH-1:0] prescaler_taps,
   output reg         timer_irq_req,
   output reg         irq
);

   // ****************************************
   // Register state
   // ****************************************
   reg  [7:0]           counter_value_reg;   // Counter
   reg  [2:0]           clock_select_reg;    // Clock select field
   reg                  global_irq_en_reg;   // Global interrupt enable
   reg                  overflow_irq_enable_reg; // Mask bit
   reg                  overflow_flag_reg;   // Overflow flag
   reg  [1:0]           irq_status_reg;      // Sticky event bits
   reg  [1:0]           irq_mask_reg;        // Event mask
   reg  [PRE_WIDTH-1:0] prescaler_reg;       // Free-running prescaler
   reg  [PRE_WIDTH-1:0] prescaler_next;
   reg                  pin_meta_reg;        // Synchroniser stage 1
   reg                  pin_sync_reg;        // Synchroniser stage 2
   reg                  pin_prev_reg;        // Edge detector history
   reg                  tick_reg;            // Registered timer tick

   // ****************************************
   // Bus decode
   // ****************************************
   wire access   = psel & penable;           // Access phase, zero wait
   wire wr_en    = access & pwrite;
   wire rd_en    = access & ~pwrite;
   wire hit_cnt  = (paddr == `EBT_OFS_COUNTER);
   wire hit_ctl  = (paddr == `EBT_OFS_CONTROL);
   wire hit_msk  = (paddr == `EBT_OFS_MASK);
   wire hit_flg  = (paddr == `EBT_OFS_FLAGS);
   wire hit_ist  = (paddr == `EBT_OFS_IRQ_STAT);
   wire hit_imk  = (paddr == `EBT_OFS_IRQ_MASK);
   // Only exact word offsets decode; anything else answers with an
   // error and leaves every register untouched
   wire mapped   = hit_cnt | hit_ctl | hit_msk | hit_flg | hit_ist | hit_imk;
   // Prescaler reset from software or from the partner timer
   wire psr_wr   = wr_en & hit_ctl & pwdata[`EBT_CTRL_PSR_BIT];
   wire psr_any  = psr_wr | ext_prescaler_reset;

   // ****************************************
   // Shared prescaler
   // ****************************************
   // Runs whatever the clock select says, so the first tick lands
   // somewhere within one divisor period after enabling.
   always @*
   begin
      if (psr_any)
      begin
         prescaler_next = {PRE_WIDTH{1'b0}};
      end
      else
      begin
         prescaler_next = prescaler_reg + {{(PRE_WIDTH-1){1'b0}}, 1'b1};
      end
   end

   // Tap pulses fire while the low bits of the prescaler are all ones, the cycle before they wrap to zero
   // The second timer sees the same phases through prescaler_taps,
   // so a reset from either side moves both
   wire tap8    = (prescaler_reg[2:0] == 3'h7);
   wire tap64   = (prescaler_reg[5:0] == 6'h3f);
   wire tap256  = (prescaler_reg[7:0] == 8'hff);
   wire tap1024 = (prescaler_reg[9:0] == 10'h3ff);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prescaler_reg <= {PRE_WIDTH{1'b0}};
      end
      else
      begin
         prescaler_reg <= prescaler_next;
      end
   end

   // ****************************************
   // Count pin synchroniser and edge detect
   // ****************************************
   // The pin is sampled even while the port drives it as an output.
   // The first stage may go metastable; only the second stage feeds
   // the edge detector, at the price of two cycles of latency.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
      end
      else
      begin
         pin_meta_reg <= count_input_pin;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   wire rise_edge = pin_sync_reg & ~pin_prev_reg;
   wire fall_edge = ~pin_sync_reg & pin_prev_reg;

   // ****************************************
   // Clock select multiplexer
   // ****************************************
   // Changing the select while a pin edge is in flight can give one
   // stray tick; software should switch modes with the pin quiet.
   reg tick_sel;                               // Combinational tick choice
   always @*
   begin
      case (clock_select_reg)
         `EBT_CS_STOP:     tick_sel = 1'b0;
         `EBT_CS_DIV1:     tick_sel = 1'b1;
         `EBT_CS_DIV8:     tick_sel = tap8;
         `EBT_CS_DIV64:    tick_sel = tap64;
         `EBT_CS_DIV256:   tick_sel = tap256;
         `EBT_CS_DIV1024:  tick_sel = tap1024;
         `EBT_CS_EXT_FALL: tick_sel = fall_edge;
         `EBT_CS_EXT_RISE: tick_sel = rise_edge;
         default:          tick_sel = 1'b0;
      endcase
   end

   // Tick is registered; with the two sync stages the count lands
   // three clocks after the pin is first sampled.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_reg <= 1'b0;
      end
      else
      begin
         tick_reg <= tick_sel & (clock_select_reg != `EBT_CS_STOP);
      end
   end

   // ****************************************
   // Counter and overflow flag
   // ****************************************
   wire cnt_wr   = wr_en & hit_cnt;
   // A tick already registered when software stops the timer is
   // dropped, so the counter stands still while the select reads zero
   wire run_en   = (clock_select_reg != `EBT_CS_STOP);
   wire tick     = tick_reg & run_en;
   wire wrap     = tick & (counter_value_reg == `EBT_MAX_VALUE);
   wire flag_w1c = wr_en & hit_flg & pwdata[`EBT_FLAG_TOV_BIT];
   // Overflow while the write counts as lost, software owns the value
   wire ovf_evt  = wrap & ~cnt_wr;
   wire pin_evt  = tick & clock_select_reg[2] & clock_select_reg[1];

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         counter_value_reg <= `EBT_COUNT_RESET;
         overflow_flag_reg <= 1'b0;
      end
      else
      begin
         if (cnt_wr)
         begin
            counter_value_reg <= pwdata[7:0];
         end
         else if (tick)
         begin
            counter_value_reg <= counter_value_reg + 8'h01;
         end
         // A vector ack or write-one racing a wrap loses, so no overflow is missed
         // Set wins over any clear in the same cycle
         if (ovf_evt)
         begin
            overflow_flag_reg <= 1'b1;
         end
         else if (flag_w1c | ovf_vector_ack)
         begin
            overflow_flag_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // Control and mask registers
   // ****************************************
   // Plain software-owned state; the prescaler reset bit is not stored,
   // it only fires a one-cycle pulse from the bus decode
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clock_select_reg        <= `EBT_CS_RESET;
         global_irq_en_reg       <= 1'b0;
         overflow_irq_enable_reg <= 1'b0;
         irq_mask_reg            <= 2'h0;
      end
      else
      begin
         if (wr_en & hit_ctl)
         begin
            clock_select_reg  <= pwdata[`EBT_CTRL_CS_MSB:`EBT_CTRL_CS_LSB];
            global_irq_en_reg <= pwdata[`EBT_CTRL_GIE_BIT];
         end
         if (wr_en & hit_msk)
         begin
            overflow_irq_enable_reg <= pwdata[`EBT_MASK_TOIE_BIT];
         end
         if (wr_en & hit_imk)
         begin
            irq_mask_reg <= pwdata[1:0];
         end
      end
   end

   // ****************************************
   // Sticky event status, cleared on read
   // ****************************************
   wire       ist_rd = rd_en & hit_ist;
   wire [1:0] events = {pin_evt, ovf_evt};
   // Clear only the bits that were handed to software: an event that
   // lands in the setup cycle of the read is kept for the next read
   wire [1:0] status_next = (ist_rd ? (irq_status_reg & ~prdata[1:0]) : irq_status_reg)
                            | events;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_status_reg <= 2'h0;
      end
      else
      begin
         // New events survive a read in the same cycle
         irq_status_reg <= status_next;
      end
   end

   // ****************************************
   // Outputs and read data
   // ****************************************
   // Picked from the address alone; the bus stage below decides
   // whether it reaches prdata, so idle cycles read back zero
   reg [31:0] rdata_mux;                       // Read data selection
   always @*
   begin
      rdata_mux = 32'h0000_0000;
      if (hit_cnt)
      begin
         rdata_mux[7:0] = counter_value_reg;
      end
      else if (hit_ctl)
      begin
         // Prescaler reset bit always reads zero
         rdata_mux[2:0] = clock_select_reg;
         rdata_mux[`EBT_CTRL_GIE_BIT] = global_irq_en_reg;
      end
      else if (hit_msk)
      begin
         rdata_mux[`EBT_MASK_TOIE_BIT] = overflow_irq_enable_reg;
      end
      else if (hit_flg)
      begin
         rdata_mux[`EBT_FLAG_TOV_BIT] = overflow_flag_reg;
      end
      else if (hit_ist)
      begin
         rdata_mux[1:0] = irq_status_reg;
      end
      else if (hit_imk)
      begin
         rdata_mux[1:0] = irq_mask_reg;
      end
   end

   // Zero-wait slave: ready rises in the setup cycle, read data is
   // registered then, so the access phase completes on its first edge.
   // Both interrupt outputs look at next-state values so that they
   // move on the same edge as the flag and status bits they report;
   // the enables themselves take effect one edge after their write.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata              <= 32'h0000_0000;
         pready              <= 1'b0;
         pslverr             <= 1'b0;
         prescaler_reset_out <= 1'b0;
         prescaler_taps      <= {PRE_WIDTH{1'b0}};
         timer_irq_req       <= 1'b0;
         irq                 <= 1'b0;
      end
      else
      begin
         pready              <= psel & ~penable;
         pslverr             <= psel & ~penable & ~mapped;
         prdata              <= (psel & ~penable & ~pwrite) ? rdata_mux : 32'h0000_0000;
         prescaler_reset_out <= psr_wr;
         prescaler_taps      <= prescaler_next;
         timer_irq_req       <= global_irq_en_reg & overflow_irq_enable_reg
                                & (overflow_flag_reg | ovf_evt)
                                & ~(flag_w1c & ~ovf_evt)
                                & ~(ovf_vector_ack & ~ovf_evt);
         irq                 <= |(status_next & irq_mask_reg);
      end
   end

endmodule

// >>> verification/ebt_timer_properties.sv
// Port-level checker for the eight-bit timer, bound to its top module
`timescale 1ns/1ps
module ebt_timer_props #(
   parameter PRE_WIDTH = 10
)(
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic                 ovf_vector_ack,
   input wire logic                 ext_prescaler_reset,
   input wire logic                 prescaler_reset_out,
   input wire logic [PRE_WIDTH-1:0] prescaler_taps,
   input wire logic                 timer_irq_req
);
   // Exact offsets only; misaligned ones are refused
   wire logic mapped;
   assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****
   // Bus steps
   // ****
   sequence setup_s; psel && !penable; endsequence
   sequence done_s; psel && penable && pready; endsequence
   sequence psr_wr_s; done_s ##0 (pwrite && paddr == 12'h004 && pwdata[3]); endsequence
   zero_wait_a: assert property (setup_s |=> pready)
      else $error("pready late after setup");
   ready_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   idle_data_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
      else $error("prdata not zero outside read");
   err_decode_a: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr decode wrong");
   count_width_a: assert property (done_s ##0 (!pwrite && paddr == 12'h000)
      |-> prdata[31:8] == 24'h0)
      else $error("counter read upper bits set");
   psr_zero_a: assert property (done_s ##0 (!pwrite && paddr == 12'h004) |-> !prdata[3])
      else $error("prescaler reset bit reads one");
   psr_pulse_a: assert property (psr_wr_s |-> ##[1:2] prescaler_reset_out)
      else $error("no prescaler reset pulse");
   psr_single_a: assert property (prescaler_reset_out |=> !prescaler_reset_out)
      else $error("prescaler reset pulse too long");
   pre_free_a: assert property (1'b1 |=> prescaler_taps == $past(prescaler_taps) + 1'b1
      || prescaler_taps < 3)
      else $error("prescaler not free running");
   ext_restart_a: assert property (ext_prescaler_reset |-> ##[1:3] prescaler_taps < 3)
      else $error("prescaler ignored partner reset");
   ack_clear_a: assert property (ovf_vector_ack |=> !timer_irq_req)
      else $error("request stays after vector ack");
endmodule
bind ebt_timer ebt_timer_props #(.PRE_WIDTH(PRE_WIDTH)) u_props (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ovf_vector_ack,
   .ext_prescaler_reset, .prescaler_reset_out, .prescaler_taps, .timer_irq_req);

// >>> verification/ebt_pin_model.sv
// Partner model: the outside source driving the external count pin
`timescale 1ns/1ps
module ebt_pin_model (
   input wire logic pclk,
   output logic     pin
);
   // Rests low between bursts, like a driven output
   initial pin = 1'b0;
   // ****
   // Pulse burst
   // ****
   // Each level lasts half cycles; half above one clock keeps sampling safe
   task automatic pulses(input int n, input int half);
      repeat (2 * n)
      begin
         repeat (half) @(posedge pclk);
         pin <= ~pin;
      end
   endtask
endmodule

// >>> verification/tb.sv
// Self-checking testbench for the eight-bit timer
`timescale 1ns/1ps
`include "ebt_defs.vh"
module tb;
   typedef struct {logic wr; logic [11:0] a; logic [31:0] d, e; logic err;} ebt_row_t;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        ovf_vector_ack = 0, ext_prescaler_reset = 0, erv;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rdv;
   wire  [31:0] prdata;
   wire  [9:0]  prescaler_taps;
   wire         pready, pslverr, prescaler_reset_out, timer_irq_req, irq, count_input_pin;
   int          n_fail = 0, total_checks = 0, cyc = 0;
   int          dv [4] = '{8, 64, 256, 1024};
   // Plain reads, writes and refusals
   ebt_row_t rows [11] = '{
      '{0, `EBT_OFS_COUNTER, 0, 0, 0}, '{0, `EBT_OFS_CONTROL, 0, 0, 0},
      '{0, `EBT_OFS_MASK, 0, 0, 0}, '{0, `EBT_OFS_FLAGS, 0, 0, 0},
      '{1, `EBT_OFS_COUNTER, 'h5a, 0, 0}, '{0, `EBT_OFS_COUNTER, 0, 'h5a, 0},
      '{1, `EBT_OFS_CONTROL, 'h8, 0, 0}, '{0, `EBT_OFS_CONTROL, 0, 0, 0},
      '{0, 12'h018, 0, 0, 1}, '{1, 12'h002, 'h11, 0, 1}, '{0, `EBT_OFS_COUNTER, 0, 'h5a, 0}};
   always #2.5 pclk = ~pclk;
   ebt_timer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .count_input_pin, .ovf_vector_ack, .ext_prescaler_reset,
      .prescaler_reset_out, .prescaler_taps, .timer_irq_req, .irq);
   ebt_pin_model u_pin (.pclk, .pin(count_input_pin));
   // ****
   // Helpers
   // ****
   // One transfer; waits for pready, the watchdog cuts a hang
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata; erv = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task chk(input string nm, input logic [31:0] e, got);
      total_checks++;
      if (got !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, got);
      end
   endtask
   // Range compare; an unknown never lands inside
   task chk_rng(input string nm, input int lo, hi, input logic [31:0] got);
      total_checks++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         n_fail++;
         $display("[ERR] %s expected %0d..%0d seen %h", nm, lo, hi, got);
      end
   endtask
   // Run one clock select for m cycles from zero, then read the count
   task run_cs(input logic [2:0] cs, input int m, lo, hi);
      apb(1, `EBT_OFS_COUNTER, 0);
      apb(1, `EBT_OFS_CONTROL, {29'h0, cs});
      repeat (m) @(posedge pclk);
      apb(1, `EBT_OFS_CONTROL, 0);
      apb(0, `EBT_OFS_COUNTER, 0);
      chk_rng("tick count", lo, hi, rdv);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog sized well above the whole sequence
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         n_fail++;
         wrap_up();
      end
   end
   // ****
   // Main sequence
   // ****
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      foreach (rows[i])
      begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         chk("row data", rows[i].e, rdv);
         chk("row error", {31'h0, rows[i].err}, {31'h0, erv});
      end
      run_cs(1, 200, 199, 206);
      for (int k = 0; k < 4; k++)
         run_cs(3'(k + 2), 4 * dv[k], 3, 5);
      // Pin modes: five edges of the selected polarity in each burst
      for (int m = 6; m < 8; m++)
      begin
         apb(1, `EBT_OFS_COUNTER, 0);
         apb(1, `EBT_OFS_CONTROL, m);
         u_pin.pulses(5, 3);
         repeat (6) @(posedge pclk);
         apb(1, `EBT_OFS_CONTROL, 0);
         apb(0, `EBT_OFS_COUNTER, 0);
         chk("pin count", 5, rdv);
      end
      // Write while counting every cycle
      apb(1, `EBT_OFS_CONTROL, 1);
      apb(1, `EBT_OFS_COUNTER, 'h40);
      apb(0, `EBT_OFS_COUNTER, 0);
      chk_rng("written count", 'h40, 'h45, rdv);
      apb(1, `EBT_OFS_CONTROL, 0);
      apb(0, `EBT_OFS_IRQ_STAT, 0);
      apb(1, `EBT_OFS_FLAGS, 1);
      // Overflow with the enable bit still clear
      apb(1, `EBT_OFS_COUNTER, 'hfe);
      apb(1, `EBT_OFS_IRQ_MASK, 1);
      apb(1, `EBT_OFS_CONTROL, 'h11);
      repeat (8) @(posedge pclk);
      apb(1, `EBT_OFS_CONTROL, 'h10);
      apb(0, `EBT_OFS_COUNTER, 0);
      chk_rng("wrapped count", 1, 16, rdv);
      apb(0, `EBT_OFS_FLAGS, 0);
      chk("flag", 1, rdv);
      chk("req masked", 0, timer_irq_req);
      chk("irq line", 1, irq);
      apb(0, `EBT_OFS_IRQ_STAT, 0);
      chk("status", 1, rdv);
      apb(1, `EBT_OFS_MASK, 1);
      // Request follows the enable one edge after its write
      repeat (2) @(negedge pclk);
      chk("irq after read", 0, irq);
      chk("req", 1, timer_irq_req);
      @(posedge pclk) ovf_vector_ack <= 1;
      @(posedge pclk) ovf_vector_ack <= 0;
      apb(0, `EBT_OFS_FLAGS, 0);
      chk("flag after ack", 0, rdv);
      // Second overflow, global enable off, then write-one clear
      apb(1, `EBT_OFS_COUNTER, 'hff);
      apb(1, `EBT_OFS_CONTROL, 'h1);
      apb(1, `EBT_OFS_CONTROL, 'h0);
      apb(0, `EBT_OFS_FLAGS, 0);
      chk("flag again", 1, rdv);
      chk("req no global", 0, timer_irq_req);
      apb(1, `EBT_OFS_FLAGS, 1);
      apb(0, `EBT_OFS_FLAGS, 0);
      chk("flag cleared", 0, rdv);
      // Partner prescaler reset
      @(posedge pclk) ext_prescaler_reset <= 1;
      @(posedge pclk) ext_prescaler_reset <= 0;
      @(posedge pclk);
      @(negedge pclk);
      chk_rng("taps restart", 0, 3, prescaler_taps);
      // Reset in mid-run
      @(posedge pclk) presetn <= 0;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      apb(0, `EBT_OFS_MASK, 0);
      chk("mask reset", 0, rdv);
      apb(0, `EBT_OFS_COUNTER, 0);
      chk("counter reset", 0, rdv);
      wrap_up();
   end
endmodule
